// ===== src/clock_gen_pkg.sv
package clock_gen_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_MULT     = 8'h04;
  localparam logic [7:0]  ADDR_WORD     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h14;
  // Control register fields
  localparam int          CTRL_INT_ON   = 0;
  localparam int          CTRL_EXT_ON   = 1;
  localparam int          CTRL_SEL_EXT  = 2;
  // Interrupt status fields
  localparam int          IRQ_RANGE     = 0;
  localparam int          IRQ_LOCK      = 1;
  localparam int          IRQ_UNLOCK    = 2;
  // Reset values
  localparam logic [2:0]  RST_CTRL      = 3'h1;
  localparam logic [7:0]  RST_MULT      = 8'h01;
  localparam logic [11:0] RST_WORD      = 12'h800;
  localparam logic [2:0]  RST_MASK      = 3'h0;
  // Oscillator word limits and loop corrections
  localparam logic [3:0]  DIV_SLOWEST   = 4'h9;
  localparam logic [11:0] WORD_MAX      = 12'h9FF;
  localparam logic [11:0] CORR_LARGE    = 12'h020;
  localparam logic [11:0] CORR_MID      = 12'h008;
  localparam logic [11:0] CORR_SMALL    = 12'h001;

  typedef enum logic [2:0] {
    BAND_LT_085  = 3'b000,
    BAND_085_095 = 3'b001,
    BAND_095_100 = 3'b010,
    BAND_100_105 = 3'b011,
    BAND_105_115 = 3'b100,
    BAND_GT_115  = 3'b101
  } err_band_e;

  typedef struct packed {
    logic [3:0] div;
    logic [7:0] stg;
  } ctrl_word_s;
endpackage

// ===== src/clock_gen_module.sv
// Added by the designer: the address-and-strobe port and the register addresses.
module clock_gen_module (
  // Clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_we,
  input  wire logic                      reg_re,
  output logic      [15:0]               reg_rdata,
  // Plant inputs
  input  wire logic                      stop_mode,
  input  wire logic                      ext_clk_in,
  input  wire clock_gen_pkg::err_band_e  err_band,
  // Clock outputs and status
  output logic                           int_clock,
  output logic                           ext_clock,
  output logic                           base_clock,
  output logic                           osc_out_clock,
  output logic                           gen_out_clock,
  output logic                           gen_stop,
  output logic                           int_clock_enable,
  output logic                           ext_clock_enable,
  output logic                           filter_stable_flag,
  output logic                           irq
);
  logic [2:0]                ctrl_r;
  logic [7:0]                mult_r;
  clock_gen_pkg::ctrl_word_s word_r, word_nxt, word_step;
  logic [11:0]               dco_cnt_r;
  logic [7:0]                mod_cnt_r, mod_nxt;
  logic [2:0]                stat_r, stat_nxt, mask_r, ev;
  logic [3:0]                div_eff;
  logic int_r, ext_r, base_r, osc_r, gen_r, stop_r, int_en_r, ext_en_r;
  logic stable_r, stable_nxt, irq_r;
  logic [15:0]               rdata_r;
  logic int_en_nxt, ext_en_nxt, dco_wrap, int_nxt, int_rise;
  logic pass, base_nxt, base_rise, near, osc_nxt;
  logic wr_ctrl, wr_mult, wr_word, wr_stat, wr_mask;

  assign wr_ctrl = reg_we && reg_addr == clock_gen_pkg::ADDR_CTRL;
  assign wr_mult = reg_we && reg_addr == clock_gen_pkg::ADDR_MULT;
  assign wr_word = reg_we && reg_addr == clock_gen_pkg::ADDR_WORD;
  assign wr_stat = reg_we && reg_addr == clock_gen_pkg::ADDR_IRQ_STAT;
  assign wr_mask = reg_we && reg_addr == clock_gen_pkg::ADDR_IRQ_MASK;

  assign int_en_nxt = ctrl_r[clock_gen_pkg::CTRL_INT_ON] & ~stop_mode;
  assign ext_en_nxt = ctrl_r[clock_gen_pkg::CTRL_EXT_ON] & ~stop_mode;

  assign div_eff = (word_r.div > clock_gen_pkg::DIV_SLOWEST) ?
                   clock_gen_pkg::DIV_SLOWEST : word_r.div;
  assign dco_wrap = dco_cnt_r >= {div_eff, word_r.stg};
  assign int_nxt  = int_en_nxt & (dco_wrap ? ~int_r : int_r);
  assign int_rise = int_nxt & ~int_r;

  always_comb begin
    mod_nxt = mod_cnt_r;
    if (!int_en_nxt)
      mod_nxt = 8'h00;
    else if (int_rise)
      mod_nxt = (mod_cnt_r >= 8'(mult_r - 8'h01)) ? 8'h00 :
                8'(mod_cnt_r + 8'h01);
  end

  assign pass      = mult_r <= 8'h01;
  assign base_nxt  = int_en_nxt & (pass ? int_nxt :
                     (mod_nxt < (mult_r >> 1)));
  assign base_rise = base_nxt & ~base_r;

  always_comb begin
    case (err_band)
      clock_gen_pkg::BAND_LT_085:  word_step = word_r - clock_gen_pkg::CORR_LARGE;
      clock_gen_pkg::BAND_085_095: word_step = word_r - clock_gen_pkg::CORR_MID;
      clock_gen_pkg::BAND_095_100: word_step = word_r - clock_gen_pkg::CORR_SMALL;
      clock_gen_pkg::BAND_100_105: word_step = word_r + clock_gen_pkg::CORR_SMALL;
      clock_gen_pkg::BAND_105_115: word_step = word_r + clock_gen_pkg::CORR_MID;
      clock_gen_pkg::BAND_GT_115:  word_step = word_r + clock_gen_pkg::CORR_LARGE;
      default:                     word_step = word_r;
    endcase
  end

  always_comb begin
    word_nxt = word_r;
    if (wr_word)
      word_nxt = reg_wdata[11:0];
    else if (base_rise)
      word_nxt = word_step;
  end

  assign near = err_band == clock_gen_pkg::BAND_095_100 ||
                err_band == clock_gen_pkg::BAND_100_105;
  assign stable_nxt = int_en_nxt & (base_rise ? near : stable_r);

  assign ev[clock_gen_pkg::IRQ_RANGE]  =
    word_nxt.div > clock_gen_pkg::DIV_SLOWEST &&
    word_r.div <= clock_gen_pkg::DIV_SLOWEST;
  assign ev[clock_gen_pkg::IRQ_LOCK]   = stable_nxt & ~stable_r;
  assign ev[clock_gen_pkg::IRQ_UNLOCK] = stable_r & ~stable_nxt;
  // Set beats a same-cycle clear
  assign stat_nxt = (stat_r & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | ev;

  assign osc_nxt = ctrl_r[clock_gen_pkg::CTRL_SEL_EXT] ? ext_r : int_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= clock_gen_pkg::RST_CTRL;
      mult_r <= clock_gen_pkg::RST_MULT;
      mask_r <= clock_gen_pkg::RST_MASK;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[2:0];
      if (wr_mult)
        mult_r <= reg_wdata[7:0];
      if (wr_mask)
        mask_r <= reg_wdata[2:0];
    end
  end

  // stop drives enables and clocks low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_r   <= 1'b0;
      int_en_r <= 1'b0;
      ext_en_r <= 1'b0;
      ext_r    <= 1'b0;
    end else if (ce) begin
      stop_r   <= stop_mode;
      int_en_r <= int_en_nxt;
      ext_en_r <= ext_en_nxt;
      ext_r    <= ext_en_nxt & ext_clk_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dco_cnt_r <= 12'h000;
      int_r     <= 1'b0;
      mod_cnt_r <= 8'h00;
      base_r    <= 1'b0;
    end else if (ce) begin
      dco_cnt_r <= (!int_en_nxt || dco_wrap) ? 12'h000 :
                   12'(dco_cnt_r + 12'h001);
      int_r     <= int_nxt;
      mod_cnt_r <= mod_nxt;
      base_r    <= base_nxt;
    end
  end

  // carry and borrow ride the 12-bit sum
  // out-of-range word left for the loop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r   <= clock_gen_pkg::RST_WORD;
      stable_r <= 1'b0;
    end else if (ce) begin
      word_r   <= word_nxt;
      stable_r <= stable_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_r <= 1'b0;
      gen_r <= 1'b0;
    end else if (ce) begin
      osc_r <= osc_nxt;
      gen_r <= stop_mode ? 1'b0 : gen_r ^ (osc_nxt & ~osc_r);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r  <= 3'h0;
      irq_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else if (ce) begin
      stat_r  <= stat_nxt;
      irq_r   <= |(stat_nxt & mask_r);
      rdata_r <= 16'h0000;
      if (reg_re) begin
        case (reg_addr)
          clock_gen_pkg::ADDR_CTRL:     rdata_r <= {13'h0000, ctrl_r};
          clock_gen_pkg::ADDR_MULT:     rdata_r <= {8'h00, mult_r};
          clock_gen_pkg::ADDR_WORD:     rdata_r <= {4'h0, word_r};
          clock_gen_pkg::ADDR_STATUS:
            rdata_r <= {12'h000, ext_en_r, int_en_r, stop_r, stable_r};
          clock_gen_pkg::ADDR_IRQ_STAT: rdata_r <= {13'h0000, stat_r};
          clock_gen_pkg::ADDR_IRQ_MASK: rdata_r <= {13'h0000, mask_r};
          default:                      rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata          = rdata_r;
  assign int_clock          = int_r;
  assign ext_clock          = ext_r;
  assign base_clock         = base_r;
  assign osc_out_clock      = osc_r;
  assign gen_out_clock      = gen_r;
  assign gen_stop           = stop_r;
  assign int_clock_enable   = int_en_r;
  assign ext_clock_enable   = ext_en_r;
  assign filter_stable_flag = stable_r;
  assign irq                = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_band_step;
    ce && base_rise && !wr_word;
  endsequence
  sequence s_osc_rise;
    ce && !stop_mode && osc_nxt && !osc_r;
  endsequence

  property p_stop_low;
    stop_r |-> !int_r && !ext_r && !base_r;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("clock high during stop");

  // Reset released on an edge still resets the flop there
  property p_int_en;
    ce |=> int_en_r == $past(ctrl_r[0] && !stop_mode && rst_n);
  endproperty
  a_int_en: assert property (p_int_en)
    else $error("internal enable wrong");

  property p_int_off;
    !int_en_r |-> !int_r && !base_r;
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("internal clocks active while off");

  property p_ext_en;
    ce |=> ext_en_r == $past(ctrl_r[1] && !stop_mode) &&
           (ext_en_r || !ext_r);
  endproperty
  a_ext_en: assert property (p_ext_en)
    else $error("external enable or clock wrong");

  property p_pass;
    int_en_r && mult_r <= 8'h01 && $past(mult_r) <= 8'h01 &&
    $past(int_en_r) |-> base_r == int_r;
  endproperty
  a_pass: assert property (p_pass)
    else $error("base not passing internal clock");

  property p_fast_step;
    s_band_step ##0 err_band == clock_gen_pkg::BAND_LT_085
      |=> word_r == 12'($past(word_r) - 12'h020);
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("large decrement wrong");

  property p_slow_step;
    s_band_step ##0 err_band == clock_gen_pkg::BAND_100_105
      |=> word_r == 12'($past(word_r) + 12'h001);
  endproperty
  a_slow_step: assert property (p_slow_step)
    else $error("unit increment wrong");

  property p_stable;
    s_band_step |=> stable_r == $past(near);
  endproperty
  a_stable: assert property (p_stable)
    else $error("stable flag wrong");

  property p_dco_clamp;
    dco_cnt_r <= 12'h9FF;
  endproperty
  a_dco_clamp: assert property (p_dco_clamp)
    else $error("oscillator period beyond slowest");

  property p_gen_half;
    s_osc_rise |=> gen_r != $past(gen_r);
  endproperty
  a_gen_half: assert property (p_gen_half)
    else $error("gen_out did not toggle");
endmodule // clock_gen_module

// ===== test/bus_clock_model.sv
module bus_clock_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Generator side
  input  wire logic gen_out_clock,
  // Derived bus clock
  output logic      bus_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gen_d_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_d_r   <= 1'b0;
      bus_clock <= 1'b0;
    end else begin
      gen_d_r <= gen_out_clock;
      if (gen_out_clock && !gen_d_r) bus_clock <= !bus_clock;
    end
  end
endmodule // bus_clock_model

// ===== test/clock_gen_module_test.sv
module clock_gen_module_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk, rst_n, reg_we, reg_re, ce;
  logic                     stop_mode, ext_clk_in, bus_clock, irq;
  logic [7:0]               reg_addr;
  logic [15:0]              reg_wdata, reg_rdata, d;
  clock_gen_pkg::err_band_e err_band;
  logic                     int_clock, ext_clock, base_clock;
  logic                     osc_out_clock, gen_out_clock, gen_stop;
  logic                     int_clock_enable, ext_clock_enable;
  logic                     filter_stable_flag;
  logic [4:0]               sg, pv;
  int                       n_fail, n_tests, w, b, k, c1, c2, cnt[5];
  int                       corr[6] = '{-32, -8, -1, 1, 8, 32};
  int                       nv[4] = '{0, 1, 3, 4};
  logic [7:0]               ad[6];
  logic [15:0]              rv[6];
  assign sg = {base_clock, bus_clock, gen_out_clock, osc_out_clock, int_clock};
  clock_gen_module dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .stop_mode(stop_mode), .ext_clk_in(ext_clk_in),
    .err_band(err_band), .int_clock(int_clock), .ext_clock(ext_clock),
    .base_clock(base_clock), .osc_out_clock(osc_out_clock),
    .gen_out_clock(gen_out_clock), .gen_stop(gen_stop),
    .int_clock_enable(int_clock_enable),
    .ext_clock_enable(ext_clock_enable),
    .filter_stable_flag(filter_stable_flag), .irq(irq));
  bus_clock_model part_u (.core_clk(core_clk), .rst_n(rst_n),
    .gen_out_clock(gen_out_clock), .bus_clock(bus_clock));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Free-running source, so ungated paths show at once
  always @(posedge core_clk) ext_clk_in <= ~ext_clk_in;
  task give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] seen, input logic [15:0] e);
    n_tests++;
    if (seen !== e) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", s, e, seen);
    end
  endtask
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task band(input int v);
    @(posedge core_clk);
    err_band <= clock_gen_pkg::err_band_e'(v);
  endtask
  // Waits for signal i to change to v, counting rises; k is cycles taken
  task wt(input int i, input logic v);
    pv = sg;
    for (k = 1; k <= 6000; k++) begin
      tick();
      for (int j = 0; j < 5; j++) if (sg[j] && !pv[j]) cnt[j]++;
      if (sg[i] === v && pv[i] !== v) return;
      pv = sg;
    end
    n_fail++;
    give_verdict();
  endtask
  initial begin
    rst_n = 1'b0; reg_we = 1'b0; reg_re = 1'b0; reg_addr = 8'h00;
    ce = 1'b1;
    reg_wdata = 16'h0000; stop_mode = 1'b0; ext_clk_in = 1'b0;
    err_band = clock_gen_pkg::BAND_095_100; n_fail = 0; n_tests = 0;
    ad = '{clock_gen_pkg::ADDR_CTRL, clock_gen_pkg::ADDR_MULT,
      clock_gen_pkg::ADDR_WORD, clock_gen_pkg::ADDR_IRQ_MASK,
      clock_gen_pkg::ADDR_IRQ_STAT, 8'h18};
    rv = '{16'(clock_gen_pkg::RST_CTRL), 16'(clock_gen_pkg::RST_MULT),
      16'(clock_gen_pkg::RST_WORD), 16'h0000, 16'h0000, 16'h0000};
    void'($urandom(77));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ad[i]);
      chk("reset", d, rv[i]);
    end
    wr(clock_gen_pkg::ADDR_WORD, 16'h0110);
    w = 'h110;
    for (int i = 0; i < 12; i++) begin
      b = (i == 0) ? 0 : $urandom % 6;
      if (w > 'h200) b = b % 3;
      if (w < 'h40) b = b % 3 + 3;
      band(b);
      wt(4, 1'b1);
      w = (w + corr[b]) & 'hFFF;
      rd(clock_gen_pkg::ADDR_WORD);
      chk("word", d, 16'(w));
      chk("stable", 16'(filter_stable_flag), 16'(b == 2 || b == 3));
    end
    for (int i = 0; i < 8; i++) begin
      wr(clock_gen_pkg::ADDR_CTRL, 16'(i % 4));
      @(posedge core_clk);
      stop_mode <= i[2];
      c1 = 0;
      c2 = 0;
      repeat (3) tick();
      repeat (40) begin
        tick();
        c1 |= int_clock | base_clock;
        c2 |= ext_clock;
      end
      chk("int_en", 16'(int_clock_enable), 16'(i[0] & !i[2]));
      chk("ext_en", 16'(ext_clock_enable), 16'(i[1] & !i[2]));
      chk("stop", 16'(gen_stop), 16'(i[2]));
      if (!(i[0] && !i[2])) chk("int_low", 16'(c1), 16'h0000);
      if (!(i[1] && !i[2])) chk("ext_low", 16'(c2), 16'h0000);
      else chk("ext_run", 16'(c2), 16'h0001);
    end
    wr(clock_gen_pkg::ADDR_CTRL, 16'h0001);
    stop_mode <= 1'b0;
    wr(clock_gen_pkg::ADDR_WORD, 16'h0010);
    band(3);
    for (int i = 0; i < 4; i++) begin
      wr(clock_gen_pkg::ADDR_MULT, 16'(nv[i]));
      wt(4, 1'b1);
      wt(4, 1'b1);
      cnt = '{default: 0};
      wt(4, 1'b1);
      chk("n_div", 16'(cnt[0]), 16'(nv[i] <= 1 ? 1 : nv[i]));
    end
    // Enable low must freeze every generated clock
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (2) tick();
    pv = sg;
    repeat (60) tick();
    chk("ce_hold", 16'(sg), 16'(pv));
    @(posedge core_clk);
    ce <= 1'b1;
    wr(clock_gen_pkg::ADDR_MULT, 16'h0001);
    wt(3, 1'b1);
    cnt = '{default: 0};
    wt(3, 1'b1);
    chk("osc_per_bus", 16'(cnt[1]), 16'h0004);
    chk("gen_per_bus", 16'(cnt[2]), 16'h0002);
    // Earlier wander may have set the range flag already
    wr(clock_gen_pkg::ADDR_IRQ_STAT, 16'h0007);
    rd(clock_gen_pkg::ADDR_IRQ_STAT);
    chk("irq_pre", 16'(d[0]), 16'h0000);
    band(5);
    wr(clock_gen_pkg::ADDR_WORD, 16'h09F0);
    wt(4, 1'b1);
    band(3);
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk("half_per", 16'(k), 16'h0911);
    rd(clock_gen_pkg::ADDR_IRQ_STAT);
    chk("irq_stat", 16'(d[0]), 16'h0001);
    chk("irq_masked", 16'(irq), 16'h0000);
    wr(clock_gen_pkg::ADDR_IRQ_MASK, 16'h0001);
    tick();
    chk("irq_on", 16'(irq), 16'h0001);
    wr(clock_gen_pkg::ADDR_IRQ_STAT, 16'h0001);
    tick();
    chk("irq_clr", 16'(irq), 16'h0000);
    give_verdict();
  end
endmodule // clock_gen_module_test
